/* File: rtl/flash_read_consts.vh */
`ifndef FLASH_READ_CONSTS_VH
`define FLASH_READ_CONSTS_VH

// Read opcodes.
`define OPC_FAST_ARRAY   8'h0b
`define OPC_LOW_FREQ     8'h03
`define OPC_LOW_POWER    8'h01
`define OPC_PAGE_READ    8'hd2
`define OPC_BUF1_FAST    8'hd4
`define OPC_BUF1_SLOW    8'hd1
`define OPC_BUF2_FAST    8'hd6
`define OPC_BUF2_SLOW    8'hd3

// Dummy bytes after the address, per opcode family.
`define DUMMY_FAST_ARRAY 3'd1
`define DUMMY_NONE       3'd0
`define DUMMY_PAGE_READ  3'd4
`define DUMMY_BUF_FAST   3'd1

// Serial framing.
`define OPCODE_BITS      6'd8
`define ADDR_BITS        6'd24

// Address field positions, 528-byte mode.
`define STD_PAGE_MSB     21
`define STD_PAGE_LSB     10
`define STD_BYTE_MSB     9
// Address field positions, 512-byte mode.
`define BIN_PAGE_MSB     20
`define BIN_PAGE_LSB     9
`define BIN_BYTE_MSB     8

// Last byte index of a page or buffer.
`define STD_LAST_BYTE    10'd527
`define BIN_LAST_BYTE    10'd511

// Storage layout: all pages at 528 bytes, then buffer one, then buffer two.
`define MEM_AW           22
`define MEM_DEPTH        2163744
`define BUF1_BASE        22'h210000
`define BUF2_BASE        22'h210210

// Access kinds.
`define KIND_ARRAY       2'd0
`define KIND_PAGE        2'd1
`define KIND_BUF1        2'd2
`define KIND_BUF2        2'd3

`endif

/* File: rtl/flash_store.v */
`timescale 1ns/100ps
`include "flash_read_consts.vh"

module flash_store (
   input  wire                  i_clk,
   input  wire                  i_wr_en,
   input  wire [`MEM_AW-1:0]    i_wr_addr,
   input  wire [7:0]            i_wr_data,
   input  wire [`MEM_AW-1:0]    i_rd_addr,
   output reg  [7:0]            o_rd_data
);

   reg [7:0] mem [0:`MEM_DEPTH-1];

   // The write port only preloads contents; the read commands never write.
   always @(posedge i_clk) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_addr];
   end

endmodule

/* File: rtl/serial_flash_read_commands.v */
// Notes on behaviour
// - Chip-select fall starts a command; 8-bit opcode, address, dummies follow on serial input.
// - Opcode, address and data bits travel most significant bit first.
// - Fast array read: opcode, three address bytes, one dummy byte, then data.
// - 528-byte mode: upper 12 of 22 address bits are page, lower 10 byte.
// - 512-byte mode: address bits 20..9 are page, bits 8..0 are byte.
// - Low-frequency array read has no dummy byte; data follows the third address byte.
// - Low-power array read also has no dummy byte after the address.
// - After dummies each clock drives the next data bit; address increments itself.
// - Continuous read passes from a page's last byte to the next page's first.
// - After the last array bit, continuous read wraps to the first page.
// - Chip-select rise ends the read and releases serial output.
// - Array and page reads come from the array and leave buffers untouched.
// - Page read: three address bytes, four dummy bytes, then data.
// - Page read wraps to the first byte of the same page.
// - Buffer one opcodes d4h/d1h, buffer two d6h/d3h; fast and slow variants.
// - Buffer address: 14 dummy bits plus 10-bit index, or 15 plus 9.
// - Fast buffer reads need one dummy byte; slow buffer reads need none.
// - Buffer read wraps from the last buffer byte to its first.
`timescale 1ns/100ps
`include "flash_read_consts.vh"

module serial_flash_read_commands (
   input  wire                  i_ref_clk,
   input  wire                  i_nrst,
   input  wire                  i_cs_n,
   input  wire                  i_sck,
   input  wire                  i_si,
   input  wire                  i_page_512,
   input  wire                  i_load_en,
   input  wire [`MEM_AW-1:0]    i_load_addr,
   input  wire [7:0]            i_load_data,
   output reg                   o_so,
   output reg                   o_so_oe_n
);

   // An unknown opcode parks in the ignore state until chip select rises again.
   localparam [4:0] ST_OPCODE = 5'b00001;
   localparam [4:0] ST_ADDR   = 5'b00010;
   localparam [4:0] ST_DUMMY  = 5'b00100;
   localparam [4:0] ST_DATA   = 5'b01000;
   localparam [4:0] ST_IGNORE = 5'b10000;

   reg                  rst_meta_n;
   reg                  rst_n;

   // Pin synchronisers: bit 0 chip select, 1 clock, 2 data in, 3 page size.
   wire [3:0]           pins_raw;
   reg  [3:0]           pins_meta;
   reg  [3:0]           pins_sync;
   reg                  sck_last;

   reg  [4:0]           state;
   reg  [4:0]           next_state;
   reg  [5:0]           bit_cnt;
   reg  [23:0]          shift_in;
   reg  [1:0]           kind;
   reg  [2:0]           dummy_bytes;
   reg                  page_512;
   reg  [11:0]          page;
   reg  [9:0]           byte_idx;
   reg  [2:0]           out_idx;

   wire                 cs_n_s;
   wire                 sck_s;
   wire                 si_s;
   wire                 sck_rise;
   wire                 sck_fall;
   wire [23:0]          shift_next;
   wire [7:0]           opcode_next;
   wire [9:0]           last_byte;
   wire [`MEM_AW-1:0]   page_base;
   reg  [`MEM_AW-1:0]   rd_addr;
   wire [7:0]           rd_data;

   reg  [1:0]           dec_kind;
   reg  [2:0]           dec_dummy;
   reg                  dec_valid;

   assign pins_raw = {i_page_512, i_si, i_sck, i_cs_n};

   // Reset leaves through two flops so that no register comes out of reset on a different edge.

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : pin_sync
         always @(posedge i_ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               pins_meta[g] <= (g == 0) ? 1'b1 : 1'b0;
               pins_sync[g] <= (g == 0) ? 1'b1 : 1'b0;
            end else begin
               pins_meta[g] <= pins_raw[g];
               pins_sync[g] <= pins_meta[g];
            end
         end
      end
   endgenerate

   assign cs_n_s = pins_sync[0];
   assign sck_s  = pins_sync[1];
   assign si_s   = pins_sync[2];

   // A false edge right after reset is harmless because edges only count while selected.
   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_last <= 1'b0;
      end else begin
         sck_last <= sck_s;
      end
   end

   // Edges count only while selected, so a mode-3 idle-high clock gives no stray bit.
   assign sck_rise = !cs_n_s && sck_s && !sck_last;
   assign sck_fall = !cs_n_s && !sck_s && sck_last;

   assign shift_next  = {shift_in[22:0], si_s};
   assign opcode_next = shift_next[7:0];

   // Decoding looks at the byte that the current rising edge completes, so kind and dummy count
   // are ready on the very edge that leaves the opcode phase.
   always @* begin
      dec_kind  = `KIND_ARRAY;
      dec_dummy = `DUMMY_NONE;
      dec_valid = 1'b1;
      case (opcode_next)
         `OPC_FAST_ARRAY: begin
            dec_dummy = `DUMMY_FAST_ARRAY;
         end
         `OPC_LOW_FREQ: begin
            dec_dummy = `DUMMY_NONE;
         end
         `OPC_LOW_POWER: begin
            dec_dummy = `DUMMY_NONE;
         end
         `OPC_PAGE_READ: begin
            dec_kind  = `KIND_PAGE;
            dec_dummy = `DUMMY_PAGE_READ;
         end
         `OPC_BUF1_FAST: begin
            dec_kind  = `KIND_BUF1;
            dec_dummy = `DUMMY_BUF_FAST;
         end
         `OPC_BUF1_SLOW: begin
            dec_kind  = `KIND_BUF1;
            dec_dummy = `DUMMY_NONE;
         end
         `OPC_BUF2_FAST: begin
            dec_kind  = `KIND_BUF2;
            dec_dummy = `DUMMY_BUF_FAST;
         end
         `OPC_BUF2_SLOW: begin
            dec_kind  = `KIND_BUF2;
            dec_dummy = `DUMMY_NONE;
         end
         default: begin
            dec_valid = 1'b0;
         end
      endcase
   end

   // A deselect overrides every phase, which also ends an ignored command.
   always @* begin
      next_state = state;
      case (state)
         ST_OPCODE: begin
            if (sck_rise && bit_cnt == `OPCODE_BITS - 6'd1) begin
               next_state = dec_valid ? ST_ADDR : ST_IGNORE;
            end
         end
         ST_ADDR: begin
            if (sck_rise && bit_cnt == `ADDR_BITS - 6'd1) begin
               next_state = (dummy_bytes == `DUMMY_NONE) ? ST_DATA : ST_DUMMY;
            end
         end
         ST_DUMMY: begin
            if (sck_rise && bit_cnt == {dummy_bytes, 3'b000} - 6'd1) begin
               next_state = ST_DATA;
            end
         end
         ST_DATA: begin
            next_state = ST_DATA;
         end
         ST_IGNORE: begin
            next_state = ST_IGNORE;
         end
         default: begin
            next_state = ST_OPCODE;
         end
      endcase
      if (cs_n_s) begin
         next_state = ST_OPCODE;
      end
   end

   // Buffers follow the page size of the array, so one last-byte choice serves every kind.
   assign last_byte = page_512 ? `BIN_LAST_BYTE : `STD_LAST_BYTE;

   // Every page keeps its 528-byte footprint; 512-byte mode uses the low part.
   assign page_base = {1'b0, page, 9'h000} + {6'h00, page, 4'h0};

   // Buffers sit above the last page; only a byte field above 527 in the last page, in 528-byte mode, reaches them.
   always @* begin
      case (kind)
         `KIND_BUF1: rd_addr = `BUF1_BASE + {12'h000, byte_idx};
         `KIND_BUF2: rd_addr = `BUF2_BASE + {12'h000, byte_idx};
         default:    rd_addr = page_base + {12'h000, byte_idx};
      endcase
   end

   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= ST_OPCODE;
         bit_cnt     <= 6'h00;
         shift_in    <= 24'h000000;
         kind        <= `KIND_ARRAY;
         dummy_bytes <= `DUMMY_NONE;
         page_512    <= 1'b0;
         page        <= 12'h000;
         byte_idx    <= 10'h000;
         out_idx     <= 3'h7;
         o_so        <= 1'b0;
         o_so_oe_n   <= 1'b1;
      end else begin
         state <= next_state;
         if (cs_n_s) begin
            bit_cnt   <= 6'h00;
            out_idx   <= 3'h7;
            o_so      <= 1'b0;
            o_so_oe_n <= 1'b1;
            // The setting is taken only between commands so a frame never sees it change.
            page_512  <= pins_sync[3];
         end else begin
            if (sck_rise && state != ST_DATA && state != ST_IGNORE) begin
               shift_in <= shift_next;
               if (next_state != state) begin
                  bit_cnt <= 6'h00;
               end else begin
                  bit_cnt <= bit_cnt + 6'd1;
               end
            end
            if (state == ST_OPCODE && sck_rise && bit_cnt == `OPCODE_BITS - 6'd1) begin
               kind        <= dec_kind;
               dummy_bytes <= dec_dummy;
            end
            if (state == ST_ADDR && sck_rise && bit_cnt == `ADDR_BITS - 6'd1) begin
               if (kind == `KIND_BUF1 || kind == `KIND_BUF2) begin
                  page <= 12'h000;
                  if (page_512) begin
                     byte_idx <= {1'b0, shift_next[`BIN_BYTE_MSB:0]};
                  end else begin
                     byte_idx <= shift_next[`STD_BYTE_MSB:0];
                  end
               end else if (page_512) begin
                  page     <= shift_next[`BIN_PAGE_MSB:`BIN_PAGE_LSB];
                  byte_idx <= {1'b0, shift_next[`BIN_BYTE_MSB:0]};
               end else begin
                  page     <= shift_next[`STD_PAGE_MSB:`STD_PAGE_LSB];
                  byte_idx <= shift_next[`STD_BYTE_MSB:0];
               end
            end
            // The store answers one cycle after an address change, far inside a half link period.
            if (state == ST_DATA && sck_fall) begin
               o_so      <= rd_data[out_idx];
               o_so_oe_n <= 1'b0;
               out_idx   <= out_idx - 3'd1;
               // The pointer moves once bit 0 has left, which gives the store a whole bit time.
               if (out_idx == 3'd0) begin
                  if (byte_idx >= last_byte) begin
                     byte_idx <= 10'h000;
                     if (kind == `KIND_ARRAY) begin
                        page <= page + 12'h001;
                     end
                  end else begin
                     byte_idx <= byte_idx + 10'h001;
                  end
               end
            end
         end
      end
   end

   // The store is only read by the link, so both buffers stay as they were loaded.
   flash_store u_store (
      .i_clk     (i_ref_clk),
      .i_wr_en   (i_load_en),
      .i_wr_addr (i_load_addr),
      .i_wr_data (i_load_data),
      .i_rd_addr (rd_addr),
      .o_rd_data (rd_data)
   );

endmodule

/* File: verif/flash_read_chk.sv */
`timescale 1ns/100ps
module flash_read_chk (
   input wire i_ref_clk,
   input wire i_nrst,
   input wire i_cs_n,
   input wire i_sck,
   input wire i_si,
   input wire o_so,
   input wire o_so_oe_n
);
   logic [7:0] rises;
   logic [7:0] opc;
   logic [5:0] since_fall;
   logic [7:0] need;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   // Edges are counted on the raw pins so that a fault in the design's synchroniser cannot hide itself.
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rises <= 8'h00;
         opc <= 8'h00;
         since_fall <= 6'h3f;
      end else begin
         if (i_cs_n)
            rises <= 8'h00;
         else if ($rose(i_sck) && rises != 8'hff)
            rises <= rises + 8'h01;
         if ($rose(i_sck) && !i_cs_n && rises < 8'h08)
            opc <= {opc[6:0], i_si};
         if ($fell(i_sck))
            since_fall <= 6'h00;
         else if (since_fall != 6'h3f)
            since_fall <= since_fall + 6'h01;
      end
   end
   always_comb begin
      case (opc)
         8'h0b, 8'hd4, 8'hd6: need = 8'h28;
         8'h03, 8'h01, 8'hd1, 8'hd3: need = 8'h20;
         8'hd2: need = 8'h40;
         default: need = 8'h00;
      endcase
   end
   chk_hiz_low: assert property (o_so_oe_n |-> !o_so) else $error("so not low while released");
   chk_cs_release: assert property (i_cs_n [*6] |-> o_so_oe_n) else $error("so still driven");
   chk_drive_frame: assert property ($fell(o_so_oe_n) |-> !i_cs_n && !$past(i_cs_n, 8)) else $error("drive outside frame");
   chk_data_start: assert property ($fell(o_so_oe_n) |-> rises == need) else $error("data start count");
   chk_refuse_op: assert property (!o_so_oe_n |-> need != 8'h00) else $error("unknown opcode answered");
   chk_bit_timing: assert property (!o_so_oe_n && $changed(o_so) |-> since_fall < 6'h07) else $error("so moved late");
   chk_keep_drive: assert property (!o_so_oe_n && !i_cs_n |=> !o_so_oe_n) else $error("drive dropped in frame");
   chk_hold_high: assert property (!o_so_oe_n && i_sck && $past(i_sck, 7) |-> $stable(o_so)) else $error("so moved");
   cover property ($fell(o_so_oe_n) && need == 8'h28);
   cover property ($fell(o_so_oe_n) && need == 8'h40);
   cover property (i_cs_n && !o_so_oe_n);
endmodule
bind serial_flash_read_commands flash_read_chk i_chk (.i_ref_clk, .i_nrst, .i_cs_n, .i_sck, .i_si, .o_so, .o_so_oe_n);

/* File: verif/flash_host.sv */
`timescale 1ns/100ps
module flash_host (
   input  wire  i_clk,
   input  wire  i_so,
   input  wire  i_so_oe_n,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si
);
   logic [23:0] rx;
   logic [23:0] rx_oe_n;
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
   end
   task automatic half();
      repeat (16) @(negedge i_clk);
   endtask
   task automatic frame(input [7:0] opc, input [23:0] adr, input [2:0] nd, input [5:0] nbits);
      logic [31:0] hdr;
      hdr = {opc, adr};
      @(negedge i_clk);
      o_cs_n = 1'b0;
      repeat (4) @(negedge i_clk);
      for (int i = 0; i < 32 + 8 * nd + nbits; i++) begin
         o_sck = 1'b0;
         // Past the header the line carries nothing, so it toggles rather than holding a stale bit.
         o_si = (i < 32) ? hdr[31 - i] : ~o_si;
         half();
         o_sck = 1'b1;
         rx = {rx[22:0], i_so};
         rx_oe_n = {rx_oe_n[22:0], i_so_oe_n};
         half();
      end
      o_sck = 1'b0;
      half();
      o_cs_n = 1'b1;
      o_si = ~o_si;
      repeat (8) @(negedge i_clk);
   endtask
endmodule

/* File: verif/serial_flash_read_commands_tb_top.sv */
`timescale 1ns/100ps
`include "flash_read_consts.vh"
module serial_flash_read_commands_tb_top;
   logic              i_ref_clk = 1'b0;
   logic              i_nrst = 1'b0;
   logic              i_page_512 = 1'b0;
   logic              i_load_en = 1'b0;
   logic [`MEM_AW-1:0] i_load_addr = 22'h0;
   logic [7:0]        i_load_data = 8'h00;
   wire               cs_n, sck, si, so, so_oe_n;
   int                fails = 0;
   int                n_compared = 0;
   always #2.5 i_ref_clk = ~i_ref_clk;
   serial_flash_read_commands i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
      .i_page_512(i_page_512), .i_load_en(i_load_en), .i_load_addr(i_load_addr), .i_load_data(i_load_data),
      .o_so(so), .o_so_oe_n(so_oe_n));
   flash_host i_host (.i_clk(i_ref_clk), .i_so(so), .i_so_oe_n(so_oe_n), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
   function automatic [7:0] pat(input [21:0] a);
      pat = a[7:0] ^ a[15:8] ^ {2'b00, a[21:16]} ^ 8'h5a;
   endfunction
   task automatic complete_run();
      if (fails == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic load(input [21:0] a);
      @(negedge i_ref_clk);
      i_load_en = 1'b1;
      i_load_addr = a;
      i_load_data = pat(a);
      @(negedge i_ref_clk);
      i_load_en = 1'b0;
   endtask
   // Reads three bytes from the last byte of a page or buffer, so the second byte shows the wrap.
   task automatic rd(input [7:0] opc, input [23:0] adr, input [2:0] nd, input p512, input [21:0] s0, input [21:0] s1,
                     input ld);
      if (ld) begin
         load(s0);
         load(s1);
         load(s1 + 22'h1);
      end
      i_page_512 = p512;
      repeat (4) @(negedge i_ref_clk);
      i_host.frame(opc, adr, nd, 6'd24);
      cmp(i_host.rx, {pat(s0), pat(s1), pat(s1 + 22'h1)});
      cmp(i_host.rx_oe_n, 32'h0);
   endtask
   task automatic t_buffers();
      logic [7:0]  opc [4] = '{`OPC_BUF1_FAST, `OPC_BUF1_SLOW, `OPC_BUF2_FAST, `OPC_BUF2_SLOW};
      logic [21:0] base;
      for (int i = 0; i < 4; i++) begin
         base = (i < 2) ? `BUF1_BASE : `BUF2_BASE;
         rd(opc[i], i[0] ? 24'hffffff : 24'hfffe0f, i[0] ? `DUMMY_NONE : `DUMMY_BUF_FAST, i[0],
            base + (i[0] ? 22'h1ff : 22'h20f), base, 1'b1);
      end
   endtask
   task automatic t_fast_cross();
      rd(`OPC_FAST_ARRAY, 24'hc0060f, `DUMMY_FAST_ARRAY, 1'b0, 22'h00041f, 22'h000420, 1'b1);
   endtask
   task automatic t_low_freq_wrap();
      rd(`OPC_LOW_FREQ, 24'hffffff, `DUMMY_NONE, 1'b1, 22'h20ffef, 22'h000000, 1'b1);
   endtask
   task automatic t_low_power_wrap();
      rd(`OPC_LOW_POWER, 24'hfffe0f, `DUMMY_NONE, 1'b0, 22'h20ffff, 22'h000000, 1'b1);
   endtask
   task automatic t_page_wrap();
      rd(`OPC_PAGE_READ, 24'h000e0f, `DUMMY_PAGE_READ, 1'b0, 22'h00083f, 22'h000630, 1'b1);
   endtask
   task automatic t_buffers_kept();
      rd(`OPC_BUF1_FAST, 24'hfffe0f, `DUMMY_BUF_FAST, 1'b0, 22'h21020f, `BUF1_BASE, 1'b0);
   endtask
   task automatic t_abort_refuse();
      i_host.frame(8'h77, 24'h000000, 3'd0, 6'd8);
      cmp(i_host.rx_oe_n[7:0], 32'hff);
      i_host.frame(`OPC_FAST_ARRAY, 24'h000000, `DUMMY_FAST_ARRAY, 6'd4);
      cmp(i_host.rx_oe_n[3:0], 32'h0);
      cmp({so_oe_n, so}, 32'h2);
   endtask
   initial begin
      repeat (12) @(negedge i_ref_clk);
      i_nrst = 1'b1;
      repeat (6) @(negedge i_ref_clk);
      t_buffers();
      t_fast_cross();
      t_low_freq_wrap();
      t_low_power_wrap();
      t_page_wrap();
      t_buffers_kept();
      t_abort_refuse();
      complete_run();
   end
   // Eleven frames of under 3000 cycles each need under 165 us, so nearly twice that means a hang.
   initial begin
      #300000;
      fails++;
      complete_run();
   end
endmodule
